// ### timer16_pkg.sv
package timer16_pkg;

  localparam logic [4:0] OFS_CONTROL   = 5'h00;
  localparam logic [4:0] OFS_COUNT     = 5'h04;
  localparam logic [4:0] OFS_COMPARE_A = 5'h08;
  localparam logic [4:0] OFS_COMPARE_B = 5'h0C;
  localparam logic [4:0] OFS_CAPTURE   = 5'h10;
  localparam logic [4:0] OFS_FLAGS     = 5'h14;
  localparam logic [4:0] OFS_DIRECTION = 5'h18;

  localparam int CTRL_WGM_LSB   = 0;
  localparam int CTRL_CS_LSB    = 4;
  localparam int CTRL_ACT_A_LSB = 8;
  localparam int CTRL_ACT_B_LSB = 10;
  localparam int FLAG_OVF       = 0;
  localparam int FLAG_CMP_A     = 1;
  localparam int FLAG_CMP_B     = 2;
  localparam int FLAG_CAP       = 3;
  localparam int DIR_WAVE_LSB   = 2;

  localparam logic [15:0] BOTTOM    = 16'h0000;
  localparam logic [15:0] MAX       = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  localparam logic [3:0] WGM_NORMAL   = 4'h0;
  localparam logic [3:0] WGM_PC8      = 4'h1;
  localparam logic [3:0] WGM_PC9      = 4'h2;
  localparam logic [3:0] WGM_PC10     = 4'h3;
  localparam logic [3:0] WGM_CTC_A    = 4'h4;
  localparam logic [3:0] WGM_FAST8    = 4'h5;
  localparam logic [3:0] WGM_FAST9    = 4'h6;
  localparam logic [3:0] WGM_FAST10   = 4'h7;
  localparam logic [3:0] WGM_PFC_CAP  = 4'h8;
  localparam logic [3:0] WGM_PFC_A    = 4'h9;
  localparam logic [3:0] WGM_PC_CAP   = 4'hA;
  localparam logic [3:0] WGM_PC_A     = 4'hB;
  localparam logic [3:0] WGM_CTC_CAP  = 4'hC;
  localparam logic [3:0] WGM_FAST_CAP = 4'hE;
  localparam logic [3:0] WGM_FAST_A   = 4'hF;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_CTC    = 4'b0010,
    MODE_FAST   = 4'b0100,
    MODE_PHASE  = 4'b1000
  } mode_t;

  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avl_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } avl_rsp_t;

  typedef struct packed {
    logic [1:0] level;
    logic [1:0] oe_n;
  } pin_drive_t;

  typedef struct packed {
    logic [3:0]       wgm;
    logic [2:0]       cs;
    logic [1:0][1:0]  act;
    logic [15:0]      count;
    logic             up;
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] cmp_buf;
    logic [15:0]      capture;
    logic             ovf;
    logic [1:0]       cmp_flag;
    logic             cap_flag;
    logic [1:0]       dir;
    logic [1:0]       wave;
    logic [9:0]       pre;
    logic             waitreq;
    logic [31:0]      rdata;
    pin_drive_t       pin;
  } state_t;

endpackage

// ### timer16_wave.sv
`timescale 1ns/1ps

module timer16_wave (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire timer16_pkg::avl_req_t avl_req,
  output timer16_pkg::avl_rsp_t      avl_rsp,
  output timer16_pkg::pin_drive_t    wave_pin
);

  timer16_pkg::state_t s;
  timer16_pkg::state_t next_s;
  timer16_pkg::mode_t  mode;
  logic [15:0]         top;
  logic                tick;
  logic                at_top;
  logic                accept;
  logic                wr_any;

  function automatic timer16_pkg::mode_t mode_of(input logic [3:0] w);
    case (w)
      timer16_pkg::WGM_CTC_A, timer16_pkg::WGM_CTC_CAP: mode_of = timer16_pkg::MODE_CTC;
      timer16_pkg::WGM_FAST8, timer16_pkg::WGM_FAST9, timer16_pkg::WGM_FAST10,
      timer16_pkg::WGM_FAST_CAP, timer16_pkg::WGM_FAST_A: mode_of = timer16_pkg::MODE_FAST;
      timer16_pkg::WGM_PC8, timer16_pkg::WGM_PC9, timer16_pkg::WGM_PC10,
      timer16_pkg::WGM_PFC_CAP, timer16_pkg::WGM_PFC_A,
      timer16_pkg::WGM_PC_CAP, timer16_pkg::WGM_PC_A: mode_of = timer16_pkg::MODE_PHASE;
      default: mode_of = timer16_pkg::MODE_NORMAL;
    endcase
  endfunction

  // Fixed TOP values double as the write mask for compare values.
  function automatic logic [15:0] fixed_top(input logic [3:0] w);
    case (w)
      timer16_pkg::WGM_PC8, timer16_pkg::WGM_FAST8: fixed_top = timer16_pkg::TOP_8BIT;
      timer16_pkg::WGM_PC9, timer16_pkg::WGM_FAST9: fixed_top = timer16_pkg::TOP_9BIT;
      timer16_pkg::WGM_PC10, timer16_pkg::WGM_FAST10: fixed_top = timer16_pkg::TOP_10BIT;
      default: fixed_top = timer16_pkg::MAX;
    endcase
  endfunction

  function automatic logic top_is_a(input logic [3:0] w);
    top_is_a = (w == timer16_pkg::WGM_CTC_A) || (w == timer16_pkg::WGM_FAST_A) ||
               (w == timer16_pkg::WGM_PC_A) || (w == timer16_pkg::WGM_PFC_A);
  endfunction

  function automatic logic top_is_cap(input logic [3:0] w);
    top_is_cap = (w == timer16_pkg::WGM_CTC_CAP) || (w == timer16_pkg::WGM_FAST_CAP) ||
                 (w == timer16_pkg::WGM_PC_CAP) || (w == timer16_pkg::WGM_PFC_CAP);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_comb begin
    case (s.cs)
      timer16_pkg::CS_DIV1:    tick = 1'b1;
      timer16_pkg::CS_DIV8:    tick = (s.pre & timer16_pkg::MASK_DIV8) == timer16_pkg::MASK_DIV8;
      timer16_pkg::CS_DIV64:   tick = (s.pre & timer16_pkg::MASK_DIV64) == timer16_pkg::MASK_DIV64;
      timer16_pkg::CS_DIV256:  tick = (s.pre & timer16_pkg::MASK_DIV256) == timer16_pkg::MASK_DIV256;
      timer16_pkg::CS_DIV1024: tick = s.pre == timer16_pkg::MASK_DIV1024;
      default:                 tick = 1'b0;
    endcase
  end

  always_comb begin
    mode = mode_of(s.wgm);
    if (top_is_a(s.wgm)) begin
      top = s.cmp[0];
    end else if (top_is_cap(s.wgm)) begin
      top = s.capture;
    end else begin
      top = fixed_top(s.wgm);
    end
    at_top = (s.count == top);
    accept = (avl_req.read || avl_req.write) && !s.waitreq;
    wr_any = accept && avl_req.write;
  end

  always_comb begin
    next_s = s;
    next_s.pre = s.pre + 10'h001;
    // A request is held one cycle, then answered with waitrequest low.
    next_s.waitreq = 1'b1;
    if ((avl_req.read || avl_req.write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      next_s.rdata = 32'h0000_0000;
      case (avl_req.address)
        timer16_pkg::OFS_CONTROL:   next_s.rdata[11:0] = {s.act[1], s.act[0], 1'b0, s.cs, s.wgm};
        timer16_pkg::OFS_COUNT:     next_s.rdata[15:0] = s.count;
        timer16_pkg::OFS_COMPARE_A: next_s.rdata[15:0] = s.cmp_buf[0];
        timer16_pkg::OFS_COMPARE_B: next_s.rdata[15:0] = s.cmp_buf[1];
        timer16_pkg::OFS_CAPTURE:   next_s.rdata[15:0] = s.capture;
        timer16_pkg::OFS_FLAGS:     next_s.rdata[3:0] = {s.cap_flag, s.cmp_flag, s.ovf};
        timer16_pkg::OFS_DIRECTION: next_s.rdata[3:0] = {s.wave, s.dir};
        default:                    next_s.rdata = 32'h0000_0000;
      endcase
    end
    // Clears are applied before events so that a same-cycle set wins.
    if (wr_any && avl_req.address == timer16_pkg::OFS_FLAGS && avl_req.byteenable[0]) begin
      if (avl_req.writedata[timer16_pkg::FLAG_OVF]) next_s.ovf = 1'b0;
      if (avl_req.writedata[timer16_pkg::FLAG_CMP_A]) next_s.cmp_flag[0] = 1'b0;
      if (avl_req.writedata[timer16_pkg::FLAG_CMP_B]) next_s.cmp_flag[1] = 1'b0;
      if (avl_req.writedata[timer16_pkg::FLAG_CAP]) next_s.cap_flag = 1'b0;
    end
    if (tick) begin
      case (mode)
        timer16_pkg::MODE_FAST: begin
          if (at_top) begin
            next_s.count = timer16_pkg::BOTTOM;
            next_s.ovf = 1'b1;
            next_s.cmp = s.cmp_buf;
          end else begin
            next_s.count = s.count + 16'h0001;
          end
        end
        timer16_pkg::MODE_CTC: begin
          next_s.count = at_top ? timer16_pkg::BOTTOM : s.count + 16'h0001;
          if (s.count == timer16_pkg::MAX) next_s.ovf = 1'b1;
        end
        timer16_pkg::MODE_PHASE: begin
          if (s.up) begin
            if (at_top) begin
              next_s.up = 1'b0;
              next_s.count = s.count - 16'h0001;
              next_s.cmp = s.cmp_buf;
            end else begin
              next_s.count = s.count + 16'h0001;
            end
          end else if (s.count == timer16_pkg::BOTTOM) begin
            next_s.up = 1'b1;
            next_s.ovf = 1'b1;
            next_s.count = s.count + 16'h0001;
          end else begin
            next_s.count = s.count - 16'h0001;
          end
        end
        default: begin
          next_s.count = s.count + 16'h0001;
          if (s.count == timer16_pkg::MAX) next_s.ovf = 1'b1;
        end
      endcase
      if (at_top && mode != timer16_pkg::MODE_NORMAL) begin
        if (top_is_a(s.wgm)) next_s.cmp_flag[0] = 1'b1;
        if (top_is_cap(s.wgm)) next_s.cap_flag = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
        if (s.count == s.cmp[i]) begin
          next_s.cmp_flag[i] = 1'b1;
          case (s.act[i])
            timer16_pkg::ACT_TOGGLE: begin
              if (mode == timer16_pkg::MODE_NORMAL || mode == timer16_pkg::MODE_CTC ||
                  (i == 0 && top_is_a(s.wgm))) begin
                next_s.wave[i] = !s.wave[i];
              end
            end
            timer16_pkg::ACT_CLEAR: next_s.wave[i] = (mode == timer16_pkg::MODE_PHASE) && !s.up;
            timer16_pkg::ACT_SET:   next_s.wave[i] = (mode != timer16_pkg::MODE_PHASE) || s.up;
            default: next_s.wave[i] = s.wave[i];
          endcase
        end
        if (mode == timer16_pkg::MODE_FAST && at_top) begin
          if (s.act[i] == timer16_pkg::ACT_CLEAR) next_s.wave[i] = 1'b1;
          if (s.act[i] == timer16_pkg::ACT_SET) next_s.wave[i] = 1'b0;
        end
      end
    end
    if (wr_any) begin
      case (avl_req.address)
        timer16_pkg::OFS_CONTROL: begin
          if (avl_req.byteenable[0]) begin
            next_s.wgm = avl_req.writedata[timer16_pkg::CTRL_WGM_LSB +: 4];
            next_s.cs = avl_req.writedata[timer16_pkg::CTRL_CS_LSB +: 3];
          end
          if (avl_req.byteenable[1]) begin
            next_s.act[0] = avl_req.writedata[timer16_pkg::CTRL_ACT_A_LSB +: 2];
            next_s.act[1] = avl_req.writedata[timer16_pkg::CTRL_ACT_B_LSB +: 2];
          end
        end
        timer16_pkg::OFS_COUNT:
          next_s.count = merge16(s.count, avl_req.writedata, avl_req.byteenable);
        timer16_pkg::OFS_COMPARE_A, timer16_pkg::OFS_COMPARE_B: begin
          for (int i = 0; i < 2; i++) begin
            if (avl_req.address[2] == i[0]) begin
              next_s.cmp_buf[i] = merge16(s.cmp_buf[i], avl_req.writedata, avl_req.byteenable) &
                                  fixed_top(s.wgm);
              if (mode == timer16_pkg::MODE_NORMAL || mode == timer16_pkg::MODE_CTC) begin
                next_s.cmp[i] = next_s.cmp_buf[i];
              end
            end
          end
        end
        timer16_pkg::OFS_CAPTURE:
          next_s.capture = merge16(s.capture, avl_req.writedata, avl_req.byteenable);
        timer16_pkg::OFS_DIRECTION:
          if (avl_req.byteenable[0]) next_s.dir = avl_req.writedata[1:0];
        default: next_s.dir = next_s.dir;
      endcase
    end
    next_s.pin.level = next_s.wave & next_s.dir;
    next_s.pin.oe_n = ~next_s.dir;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s <= '0;
      s.waitreq <= 1'b1;
      s.up <= 1'b1;
      s.pin.oe_n <= 2'h3;
    end else begin
      s <= next_s;
    end
  end

  assign avl_rsp.readdata = s.rdata;
  assign avl_rsp.waitrequest = s.waitreq;
  assign wave_pin = s.pin;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_fast_wrap;
    tick && mode == timer16_pkg::MODE_FAST && at_top && !wr_any |=> s.count == 16'h0000 && s.ovf;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast PWM did not clear at TOP");

  property p_fast_top_flag;
    tick && s.wgm == timer16_pkg::WGM_FAST_CAP && at_top && !wr_any |=> s.cap_flag && s.ovf;
  endproperty
  a_fast_top_flag: assert property (p_fast_top_flag) else $error("TOP flags not set together");

  property p_ctc_ovf;
    tick && mode == timer16_pkg::MODE_CTC && s.count == 16'hFFFF && !wr_any |=> s.ovf;
  endproperty
  a_ctc_ovf: assert property (p_ctc_ovf) else $error("overflow missed at MAX");

  property p_cmp_flag;
    tick && s.count == s.cmp[1] && !wr_any |=> s.cmp_flag[1];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare B flag not set");

  property p_ctc_toggle;
    tick && mode == timer16_pkg::MODE_CTC && s.act[0] == 2'h1 && s.count == s.cmp[0]
      |=> s.wave[0] != $past(s.wave[0]);
  endproperty
  a_ctc_toggle: assert property (p_ctc_toggle) else $error("output A did not toggle");

  property p_pin_gate;
    !s.dir[0] |-> wave_pin.oe_n[0] && !wave_pin.level[0];
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin shows wave without direction");

  property p_div8;
    tick && s.cs == 3'h2 && !wr_any |=> (!tick || s.cs != 3'h2) [*7] ##1 (tick || s.cs != 3'h2);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 spacing wrong");

  property p_buf_load;
    tick && mode == timer16_pkg::MODE_FAST && at_top && !wr_any |=> s.cmp == $past(s.cmp_buf);
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("compare not loaded at TOP");

  property p_stopped;
    s.cs == 3'h0 && !wr_any |=> s.count == $past(s.count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("count moved with no clock");

  property p_pc_turn;
    tick && mode == timer16_pkg::MODE_PHASE && s.up && at_top && !wr_any |=> !s.up;
  endproperty
  a_pc_turn: assert property (p_pc_turn) else $error("phase correct did not turn");

  property p_ctc_clear;
    tick && mode == timer16_pkg::MODE_CTC && at_top && !wr_any |=> s.count == timer16_pkg::BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear-on-match count did not clear");

  property p_ctc_wrap;
    tick && mode == timer16_pkg::MODE_CTC && !at_top && s.count == timer16_pkg::MAX && !wr_any
      |=> s.count == timer16_pkg::BOTTOM && s.ovf;
  endproperty
  a_ctc_wrap: assert property (p_ctc_wrap) else $error("missed TOP did not wrap through zero");

  property p_ctc_top_flag;
    tick && mode == timer16_pkg::MODE_CTC && at_top && top_is_cap(s.wgm) && !wr_any |=> s.cap_flag;
  endproperty
  a_ctc_top_flag: assert property (p_ctc_top_flag) else $error("capture flag missed at TOP");

  property p_fast_step;
    tick && mode == timer16_pkg::MODE_FAST && !at_top && !wr_any |=> s.count == $past(s.count) + 16'h0001;
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast PWM count did not step up");

  property p_fast_clear;
    tick && mode == timer16_pkg::MODE_FAST && s.act[0] == timer16_pkg::ACT_CLEAR && s.count == s.cmp[0] && !at_top
      |=> !s.wave[0];
  endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("output A not cleared on match");

  property p_fast_bottom;
    tick && mode == timer16_pkg::MODE_FAST && s.act[0] == timer16_pkg::ACT_CLEAR && at_top |=> s.wave[0];
  endproperty
  a_fast_bottom: assert property (p_fast_bottom) else $error("output A not set at BOTTOM");

  property p_fast_no_toggle;
    tick && mode == timer16_pkg::MODE_FAST && s.act[0] == timer16_pkg::ACT_TOGGLE && !top_is_a(s.wgm)
      |=> s.wave[0] == $past(s.wave[0]);
  endproperty
  a_fast_no_toggle: assert property (p_fast_no_toggle) else $error("output A toggled without A as TOP");

  property p_pc_bottom;
    tick && mode == timer16_pkg::MODE_PHASE && !s.up && s.count == timer16_pkg::BOTTOM && !wr_any |=> s.up && s.ovf;
  endproperty
  a_pc_bottom: assert property (p_pc_bottom) else $error("phase correct did not turn at BOTTOM");

  property p_pc_down_set;
    tick && mode == timer16_pkg::MODE_PHASE && !s.up && s.act[0] == timer16_pkg::ACT_CLEAR && s.count == s.cmp[0]
      |=> s.wave[0];
  endproperty
  a_pc_down_set: assert property (p_pc_down_set) else $error("output A not set on down match");

  property p_pc_fixed_top;
    tick && s.wgm == timer16_pkg::WGM_PC8 && s.up && s.count == timer16_pkg::TOP_8BIT && !wr_any |=> !s.up;
  endproperty
  a_pc_fixed_top: assert property (p_pc_fixed_top) else $error("fixed TOP did not turn the count");

  property p_mask_write;
    wr_any && avl_req.address == timer16_pkg::OFS_COMPARE_A && s.wgm == timer16_pkg::WGM_FAST8
      |=> s.cmp_buf[0][15:8] == 8'h00;
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("unused compare bits not masked");

  property p_capture_now;
    wr_any && avl_req.address == timer16_pkg::OFS_CAPTURE && avl_req.byteenable[1:0] == 2'h3
      |=> s.capture == $past(avl_req.writedata[15:0]);
  endproperty
  a_capture_now: assert property (p_capture_now) else $error("capture TOP not taken at once");

endmodule // timer16_wave

// ### pin_load.sv
`timescale 1ns/1ps

// Port pins with a weak pull-down load, so a pin that is not driven reads low rather than its last level.
module pin_load (
  input  wire timer16_pkg::pin_drive_t drive,
  output logic [1:0]                   pin
);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = drive.oe_n[i] ? 1'b0 : drive.level[i];
    end
  end

endmodule // pin_load

// ### tb_timer16_ctc_fast_pwm.sv
`timescale 1ns/1ps

module tb_timer16_ctc_fast_pwm;
  logic                    sys_clk;
  logic                    nrst;
  timer16_pkg::avl_req_t   req;
  timer16_pkg::avl_rsp_t   rsp;
  timer16_pkg::pin_drive_t drive;
  logic [1:0]              pin;
  logic [15:0]             rd;
  int                      n_errors;
  int                      compares;
  int                      divs [5] = '{1, 8, 64, 256, 1024};

  timer16_wave DUT (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .avl_req  (req),
    .avl_rsp  (rsp),
    .wave_pin (drive)
  );

  pin_load load (
    .drive (drive),
    .pin   (pin)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // The request is held until waitrequest is sampled low; only then is it released.
  task automatic bus(input logic [4:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    req.address    <= a;
    req.read       <= ~w;
    req.write      <= w;
    req.writedata  <= {16'h0000, d};
    req.byteenable <= 4'h3;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 100);
    rd = rsp.readdata[15:0];
    req.read  <= 1'b0;
    req.write <= 1'b0;
    if (n >= 100) begin
      n_errors++;
      $display("MISMATCH bus_wait expected 0 seen 1");
      wrap_up();
    end
  endtask

  function automatic logic [15:0] ctl(input logic [3:0] wgm, input logic [2:0] cs, input logic [1:0] act);
    return {6'h00, act, 1'b0, cs, wgm};
  endfunction

  // Settling runs one cycle past the window (a whole number of periods) so the first buffered compare value is in force before sampling.
  // Windows are whole periods, so high time and edge count do not depend on where the window starts.
  task automatic run_wave(input logic [3:0] wgm, input logic [2:0] cs, input logic [1:0] act, input logic [15:0] cmp,
                          input logic [15:0] cap, input int win, input int exp_hi, input int exp_edges, input logic dir);
    int   hi;
    int   edges;
    logic prev;
    hi = 0;
    edges = 0;
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(wgm, timer16_pkg::CS_STOP, act));
    bus(timer16_pkg::OFS_COUNT, 1'b1, 16'h0000);
    bus(timer16_pkg::OFS_CAPTURE, 1'b1, cap);
    bus(timer16_pkg::OFS_COMPARE_A, 1'b1, cmp);
    bus(timer16_pkg::OFS_DIRECTION, 1'b1, {15'h0000, dir});
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(wgm, cs, act));
    repeat (win + 1) @(posedge sys_clk);
    prev = pin[0];
    repeat (win) begin
      @(posedge sys_clk);
      if (pin[0] === 1'b1) hi++;
      if (pin[0] !== prev) edges++;
      prev = pin[0];
    end
    if (exp_hi >= 0) chk("high_cycles", hi[15:0], exp_hi[15:0]);
    chk("edges", edges[15:0], exp_edges[15:0]);
    chk("pin_enable_n", {15'h0000, drive.oe_n[0]}, {15'h0000, ~dir});
    $display("wave test mode %0h cs %0h done", wgm, cs);
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    req = '0;
    n_errors = 0;
    compares = 0;
    repeat (5) @(posedge sys_clk);
    chk("reset_wait", {15'h0000, rsp.waitrequest}, 16'h0001);
    chk("reset_oe_n", {14'h0000, drive.oe_n}, 16'h0003);
    nrst <= 1'b1;
    bus(timer16_pkg::OFS_CONTROL, 1'b0, 16'h0000);
    chk("control", rd, 16'h0000);
    bus(5'h1C, 1'b1, 16'hFFFF);
    bus(5'h1C, 1'b0, 16'h0000);
    chk("unmapped", rd, 16'h0000);
    $display("reset test done");

    bus(timer16_pkg::OFS_COUNT, 1'b1, 16'h0005);
    repeat (20) @(posedge sys_clk);
    bus(timer16_pkg::OFS_COUNT, 1'b0, 16'h0000);
    chk("stopped_count", rd, 16'h0005);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_A, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_COMPARE_A, 1'b1, 16'hFFFF);
    bus(timer16_pkg::OFS_COUNT, 1'b1, 16'hFFF0);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_A, timer16_pkg::CS_DIV1, 2'h0));
    repeat (40) @(posedge sys_clk);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_A, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_FLAGS, 1'b0, 16'h0000);
    chk("overflow_flag", {15'h0000, rd[0]}, 16'h0001);
    chk("compare_a_flag", {15'h0000, rd[1]}, 16'h0001);
    bus(timer16_pkg::OFS_FLAGS, 1'b1, 16'h000F);
    bus(timer16_pkg::OFS_FLAGS, 1'b0, 16'h0000);
    chk("flags_cleared", {12'h000, rd[3:0]}, 16'h0000);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_CAP, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_CAPTURE, 1'b1, 16'h0010);
    bus(timer16_pkg::OFS_COUNT, 1'b1, 16'hFFF0);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_CAP, timer16_pkg::CS_DIV1, 2'h0));
    repeat (40) @(posedge sys_clk);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_CAP, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_FLAGS, 1'b0, 16'h0000);
    chk("wrap_overflow_flag", {15'h0000, rd[0]}, 16'h0001);
    chk("capture_flag", {15'h0000, rd[3]}, 16'h0001);
    $display("flag test done");

    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_FAST8, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_COMPARE_A, 1'b1, 16'h1234);
    bus(timer16_pkg::OFS_COMPARE_A, 1'b0, 16'h0000);
    chk("mask_8bit", rd, 16'h0034);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_FAST10, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_COMPARE_A, 1'b1, 16'hFFFF);
    bus(timer16_pkg::OFS_COMPARE_A, 1'b0, 16'h0000);
    chk("mask_10bit", rd, 16'h03FF);
    $display("mask test done");

    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_CTC_A, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_COMPARE_A, 1'b1, 16'h000F);
    bus(timer16_pkg::OFS_COUNT, 1'b1, 16'h0005);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_FAST_A, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_COMPARE_A, 1'b1, 16'h0003);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_FAST_A, timer16_pkg::CS_DIV1, 2'h0));
    repeat (40) @(posedge sys_clk);
    bus(timer16_pkg::OFS_COUNT, 1'b0, 16'h0000);
    chk("buffered_top", {15'h0000, rd <= 16'h0003}, 16'h0001);
    $display("buffer test done");

    foreach (divs[i]) run_wave(4'h4, 3'(i + 1), 2'h1, 16'h0000, 16'h0000, 16 * divs[i], 8 * divs[i], 16, 1'b1);
    run_wave(4'h4, 3'h1, 2'h1, 16'h0003, 16'h0000, 64, 32, 16, 1'b1);
    run_wave(4'hF, 3'h1, 2'h1, 16'h0003, 16'h0000, 64, 32, 16, 1'b1);
    run_wave(4'h5, 3'h1, 2'h1, 16'h0003, 16'h0000, 256, -1, 0, 1'b1);
    run_wave(4'h5, 3'h1, 2'h2, 16'h003F, 16'h0000, 256, 64, 2, 1'b1);
    run_wave(4'h5, 3'h1, 2'h3, 16'h003F, 16'h0000, 256, 192, 2, 1'b1);
    run_wave(4'h5, 3'h1, 2'h2, 16'h0000, 16'h0000, 256, 1, 2, 1'b1);
    run_wave(4'h5, 3'h1, 2'h2, 16'h00FF, 16'h0000, 256, 256, 0, 1'b1);
    run_wave(4'h5, 3'h1, 2'h3, 16'h00FF, 16'h0000, 256, 0, 0, 1'b1);
    run_wave(4'h6, 3'h1, 2'h2, 16'h003F, 16'h0000, 512, 64, 2, 1'b1);
    run_wave(4'h7, 3'h1, 2'h2, 16'h003F, 16'h0000, 1024, 64, 2, 1'b1);
    run_wave(4'hE, 3'h1, 2'h2, 16'h0001, 16'h0003, 16, 8, 8, 1'b1);
    run_wave(4'h1, 3'h1, 2'h2, 16'h0040, 16'h0000, 510, 128, 2, 1'b1);
    run_wave(4'hA, 3'h1, 2'h2, 16'h0001, 16'h0003, 12, 4, 4, 1'b1);
    run_wave(4'h5, 3'h1, 2'h2, 16'h003F, 16'h0000, 256, 0, 0, 1'b0);

    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_FAST_CAP, timer16_pkg::CS_STOP, 2'h0));
    bus(timer16_pkg::OFS_COUNT, 1'b1, 16'h0000);
    bus(timer16_pkg::OFS_CAPTURE, 1'b1, 16'h1000);
    bus(timer16_pkg::OFS_CONTROL, 1'b1, ctl(timer16_pkg::WGM_FAST_CAP, timer16_pkg::CS_DIV1, 2'h0));
    rd = 16'h0000;
    for (int k = 0; k < 2000 && rd <= 16'h0800; k++) bus(timer16_pkg::OFS_COUNT, 1'b0, 16'h0000);
    chk("count_climbed", {15'h0000, rd > 16'h0800}, 16'h0001);
    bus(timer16_pkg::OFS_CAPTURE, 1'b1, 16'h0100);
    repeat (4096) @(posedge sys_clk);
    bus(timer16_pkg::OFS_COUNT, 1'b0, 16'h0000);
    chk("missed_top", {15'h0000, rd > 16'h1000}, 16'h0001);
    $display("capture top test done");
    wrap_up();
  end
endmodule // tb_timer16_ctc_fast_pwm
